// ==== include/dmc_pkg.sv ====
// Shared constants and types for the DAC mute and output-mode control block
package dmc_pkg;
  // Serial control word layout
  localparam int CW_BITS    = 16;
  localparam int ADDR_LSB   = 9;
  localparam int ADDR_W     = 3;
  localparam int DATA_W     = 9;
  // Register addresses
  localparam logic [2:0] ADDR_ATTEN_L = 3'h0;
  localparam logic [2:0] ADDR_ATTEN_R = 3'h1;
  localparam logic [2:0] ADDR_CTRL2   = 3'h2;
  localparam logic [2:0] ADDR_CTRL3   = 3'h3;
  localparam logic [2:0] ADDR_ROUTE   = 3'h6;
  // Field positions
  localparam int LD_BIT     = 8;
  localparam int SMUTE_BIT  = 0;
  localparam int DEM_BIT    = 1;
  localparam int FZERO_BIT  = 2;
  localparam int ATC_BIT    = 2;
  localparam int SF_LSB     = 6;
  localparam int ZDE_BIT    = 8;
  localparam int ROUTE_LSB  = 4;
  localparam int CDD_BIT    = 6;
  localparam int KEY_LSB    = 5;
  localparam logic [3:0] KEY_VAL = 4'hF;
  // Reset values
  localparam logic [7:0] ATTEN_RST = 8'hFF;
  localparam logic [7:0] GAIN_0DB  = 8'hFF;
  localparam logic [7:0] GAIN_ZERO = 8'h00;
  localparam logic [4:0] CTRL2_RST = 5'h00;
  localparam logic [8:0] CTRL3_RST = 9'h000;
  // Timing
  localparam int SYS_MHZ       = 125;
  localparam int CLK_LOSS_US   = 100;
  localparam int CLK_LOSS_CYC  = CLK_LOSS_US * SYS_MHZ;
  localparam int LR_MISS_US    = 200;
  localparam int LR_MISS_CYC   = LR_MISS_US * SYS_MHZ;
  localparam int RAMP_SAMPLES  = 128;
  localparam int ZERO_SAMPLES  = 1024;
  localparam int BCLK_PER_LR_MIN = 32;
  localparam int SMP_W         = 24;

  typedef enum logic [1:0] {
    DEEMPH_NONE = 2'h0, DEEMPH_48K = 2'h1, DEEMPH_44K1 = 2'h2, DEEMPH_32K = 2'h3
  } dmc_deemph_t;

  typedef enum logic [1:0] {
    ROUTE_STEREO = 2'h0, ROUTE_MONO_L = 2'h1, ROUTE_SWAP = 2'h2, ROUTE_MONO_R = 2'h3
  } dmc_route_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dmc_wr_t;

  typedef struct packed {
    logic [SMP_W-1:0] lp;
    logic [SMP_W-1:0] ln;
    logic [SMP_W-1:0] rp;
    logic [SMP_W-1:0] rn;
  } dmc_quad_t;
endpackage : dmc_pkg

// ==== core/dmc_gain_ramp.sv ====
// Per-channel gain ramp that steps one code toward its goal on each step enable
`timescale 1ns/10ps
module dmc_gain_ramp (
  input  wire logic       sys_clk_i,
  input  wire logic       init_i,
  input  wire logic       step_en_i,
  input  wire logic       mute_req_i,
  input  wire logic [7:0] target_i,
  output logic      [7:0] gain_o
);
  import dmc_pkg::*;

  logic [7:0] gain_q;
  logic [7:0] gain_d;
  wire  [7:0] goal = mute_req_i ? GAIN_ZERO : target_i;

  // One 0.5dB code per step, up or down, so mute and release never click
  always_comb begin
    gain_d = gain_q;
    if (step_en_i && gain_q > goal) begin
      gain_d = gain_q - 8'h01;
    end else if (step_en_i && gain_q < goal) begin
      gain_d = gain_q + 8'h01;
    end
  end

  // Reset puts the gain at 0dB
  always_ff @(posedge sys_clk_i) begin
    if (init_i) begin
      gain_q <= GAIN_0DB;
    end else begin
      gain_q <= gain_d;
    end
  end

  assign gain_o = gain_q;
endmodule : dmc_gain_ramp

// ==== core/dmc_mute_ctrl.sv ====
// DAC mute sources, clock guards, output routing and serial control registers
// Overview of operation
// - De-emphasis field: 00 none, 01 48kHz, 10 44.1kHz, 11 32kHz.
// - Zero-detect enable low disables zero muting; high enables it.
// - Route register locked after reset; key write to register two unlocks.
// - Unlocked route field: 00 stereo, 10 swapped, 01 mono left, 11 mono right.
// - Mono left: left on LP and RN, inverted left on LN and RP.
// - Mono right: right on LN and RP, inverted right on LP and RN.
// - Master clock idle about 100us forces analog mute and filter reset.
// - Clock-loss disable bit high suppresses the clock-loss mute and reset.
// - Automute needs enable and 1024 zero sample pairs; non-zero clears it.
// - Automute drives only the analog mute, never filters or gain.
// - Mute pin or soft mute ramps gain down; analog mute at zero gain.
// - Clock loss asserts analog reset and mute; restart reinitialises filters.
// - Missing LR clock or bad bit ratio resets and mutes analog, reinits filters.
// - Reset pin resets digital path, gain to 0dB, asserts analog reset and mute.
// - Separate analog filter reset and analog output gate outputs.
// - Force-zero bit holds outputs at bipolar zero; filters keep running.
// - Soft mute leaves stored attenuation intact so release restores gain.
`timescale 1ns/10ps
module dmc_mute_ctrl #(
  parameter int LOSS_CYC = dmc_pkg::CLK_LOSS_CYC,
  parameter int LRMISS_CYC = dmc_pkg::LR_MISS_CYC
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     reset_pin_n_i,
  input  wire logic                     mute_pin_n_i,
  input  wire logic                     ctl_clk_i,
  input  wire logic                     ctl_data_i,
  input  wire logic                     ctl_latch_i,
  input  wire logic                     mclk_i,
  input  wire logic                     lrclk_i,
  input  wire logic                     bclk_i,
  input  wire logic                     smp_valid_i,
  input  wire logic [dmc_pkg::SMP_W-1:0] smp_left_i,
  input  wire logic [dmc_pkg::SMP_W-1:0] smp_right_i,
  output dmc_pkg::dmc_quad_t            dac_out_o,
  output logic [7:0]                    gain_left_o,
  output logic [7:0]                    gain_right_o,
  output dmc_pkg::dmc_deemph_t          deemph_rate_o,
  output logic                          filter_init_o,
  output logic                          analog_filter_reset_o,
  output logic                          analog_output_gate_o
);
  import dmc_pkg::*;

  typedef enum logic [2:0] {
    GRD_RUN = 3'b001, GRD_LOST = 3'b010, GRD_RESTART = 3'b100
  } dmc_grd_t;

  // Saturating negate: the most negative code has no positive twin
  function automatic logic [SMP_W-1:0] neg_sat(input logic [SMP_W-1:0] v);
    logic [SMP_W-1:0] r;
    r = (v == {1'b1, {(SMP_W-1){1'b0}}}) ? {1'b0, {(SMP_W-1){1'b1}}} : (~v + 1'b1);
    return r;
  endfunction : neg_sat

  // Two-flop synchronisers; all but the reset and mute pins add a third stage for edge detection
  logic [2:0] s_cclk_q, s_cdat_q, s_clat_q, s_mclk_q, s_lr_q, s_bclk_q;
  logic [1:0] s_rstp_q, s_mute_q;
  always_ff @(posedge sys_clk_i) begin
    s_cclk_q <= {s_cclk_q[1:0], ctl_clk_i};
    s_cdat_q <= {s_cdat_q[1:0], ctl_data_i};
    s_clat_q <= {s_clat_q[1:0], ctl_latch_i};
    s_mclk_q <= {s_mclk_q[1:0], mclk_i};
    s_lr_q   <= {s_lr_q[1:0], lrclk_i};
    s_bclk_q <= {s_bclk_q[1:0], bclk_i};
    s_rstp_q <= {s_rstp_q[0], reset_pin_n_i};
    s_mute_q <= {s_mute_q[0], mute_pin_n_i};
  end

  wire cclk_rise = s_cclk_q[1] & ~s_cclk_q[2];
  wire clat_rise = s_clat_q[1] & ~s_clat_q[2];
  wire mclk_edge = s_mclk_q[1] ^ s_mclk_q[2];
  wire lr_edge   = s_lr_q[1] ^ s_lr_q[2];
  wire lr_rise   = s_lr_q[1] & ~s_lr_q[2];
  wire bclk_rise = s_bclk_q[1] & ~s_bclk_q[2];
  wire pin_rst   = ~s_rstp_q[1];
  wire dig_rst   = rst_i | pin_rst;

  // Serial shift register; word taken on the latch rising edge
  logic [CW_BITS-1:0] shift_q;
  always_ff @(posedge sys_clk_i) begin
    if (cclk_rise) begin
      shift_q <= {shift_q[CW_BITS-2:0], s_cdat_q[2]};
    end
  end
  dmc_wr_t wr;
  assign wr = dmc_wr_t'(shift_q[ADDR_LSB+ADDR_W-1:0]);
  wire wr_stb  = clat_rise & ~dig_rst;
  wire key_hit = wr_stb && wr.addr == ADDR_CTRL2
                 && wr.data[KEY_LSB+3:KEY_LSB] == KEY_VAL;

  // Register file
  logic [7:0] atten_l_q, atten_r_q, tgt_l_q, tgt_r_q;
  logic [4:0] ctrl2_q;
  logic [8:0] ctrl3_q;
  logic [1:0] route_q;
  logic       cdd_q, unlock_q;
  always_ff @(posedge sys_clk_i) begin
    if (dig_rst) begin
      atten_l_q <= ATTEN_RST;
      atten_r_q <= ATTEN_RST;
      tgt_l_q   <= ATTEN_RST;
      tgt_r_q   <= ATTEN_RST;
      ctrl2_q   <= CTRL2_RST;
      ctrl3_q   <= CTRL3_RST;
      route_q   <= ROUTE_STEREO;
      cdd_q     <= 1'b0;
      unlock_q  <= 1'b0;
    end else if (wr_stb) begin
      case (wr.addr)
        ADDR_ATTEN_L: begin
          atten_l_q <= wr.data[7:0];
          if (wr.data[LD_BIT]) begin
            tgt_l_q <= wr.data[7:0];
            tgt_r_q <= ctrl3_q[ATC_BIT] ? wr.data[7:0] : atten_r_q;
          end
        end
        ADDR_ATTEN_R: begin
          atten_r_q <= wr.data[7:0];
          if (wr.data[LD_BIT]) begin
            tgt_l_q <= atten_l_q;
            tgt_r_q <= ctrl3_q[ATC_BIT] ? atten_l_q : wr.data[7:0];
          end
        end
        ADDR_CTRL2: begin
          ctrl2_q <= wr.data[4:0];
          if (key_hit) begin
            unlock_q <= 1'b1;
          end
        end
        ADDR_CTRL3: ctrl3_q <= wr.data;
        ADDR_ROUTE: begin
          if (unlock_q) begin
            route_q <= wr.data[ROUTE_LSB+1:ROUTE_LSB];
            cdd_q   <= wr.data[CDD_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  wire        zde      = ctrl3_q[ZDE_BIT];
  wire        fzero    = ctrl2_q[FZERO_BIT];
  wire        mute_req = ctrl2_q[SMUTE_BIT] | ~s_mute_q[1];
  dmc_route_t mode;
  assign mode = dmc_route_t'(route_q);

  // Ramp step every 128 samples; stored attenuation is never touched by mute
  logic [6:0] ramp_cnt_q;
  always_ff @(posedge sys_clk_i) begin
    if (dig_rst) begin
      ramp_cnt_q <= 7'h00;
    end else if (smp_valid_i) begin
      ramp_cnt_q <= ramp_cnt_q + 7'h01;
    end
  end
  wire step_en = smp_valid_i && ramp_cnt_q == 7'(RAMP_SAMPLES - 1);

  logic [7:0] gain_l, gain_r;
  dmc_gain_ramp u_ramp_l (
    .sys_clk_i  (sys_clk_i),
    .init_i     (dig_rst),
    .step_en_i  (step_en),
    .mute_req_i (mute_req),
    .target_i   (tgt_l_q),
    .gain_o     (gain_l)
  );
  dmc_gain_ramp u_ramp_r (
    .sys_clk_i  (sys_clk_i),
    .init_i     (dig_rst),
    .step_en_i  (step_en),
    .mute_req_i (mute_req),
    .target_i   (tgt_r_q),
    .gain_o     (gain_r)
  );
  wire gain_zero = gain_l == GAIN_ZERO && gain_r == GAIN_ZERO;

  // Zero detector counts sample pairs, saturating at the limit
  logic [10:0] zcnt_q;
  logic        automute_q;
  wire         smp_zero = smp_left_i == '0 && smp_right_i == '0;
  always_ff @(posedge sys_clk_i) begin
    if (dig_rst) begin
      zcnt_q     <= 11'h000;
      automute_q <= 1'b0;
    end else begin
      if (smp_valid_i && !smp_zero) begin
        zcnt_q <= 11'h000;
      end else if (smp_valid_i && zcnt_q != 11'(ZERO_SAMPLES)) begin
        zcnt_q <= zcnt_q + 11'h001;
      end
      automute_q <= zde && !(smp_valid_i && !smp_zero)
                    && (zcnt_q == 11'(ZERO_SAMPLES)
                        || (smp_valid_i && zcnt_q == 11'(ZERO_SAMPLES - 1)));
    end
  end

  // Master clock guard; watchdog on the clock the converter runs from
  logic [31:0] idle_q;
  dmc_grd_t    grd_q, grd_d;
  always_comb begin
    grd_d = grd_q;
    case (grd_q)
      GRD_RUN:     if (!cdd_q && idle_q >= 32'(LOSS_CYC)) grd_d = GRD_LOST;
      GRD_LOST:    if (cdd_q || mclk_edge) grd_d = GRD_RESTART;
      GRD_RESTART: grd_d = GRD_RUN;
      default:     grd_d = GRD_RUN;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (dig_rst) begin
      grd_q  <= GRD_RUN;
      idle_q <= 32'h0000_0000;
    end else begin
      grd_q  <= grd_d;
      idle_q <= mclk_edge ? 32'h0000_0000 : idle_q + {31'h0, idle_q < 32'(LOSS_CYC)};
    end
  end
  wire clk_lost = grd_q != GRD_RUN;

  // LR clock guard: presence and bit clocks per frame
  logic [31:0] lr_idle_q;
  logic [7:0]  bcnt_q;
  logic        ratio_bad_q;
  always_ff @(posedge sys_clk_i) begin
    if (dig_rst) begin
      lr_idle_q   <= 32'h0000_0000;
      bcnt_q      <= 8'h00;
      ratio_bad_q <= 1'b0;
    end else begin
      lr_idle_q <= lr_edge ? 32'h0000_0000
                 : lr_idle_q + {31'h0, lr_idle_q < 32'(LRMISS_CYC)};
      if (lr_rise) begin
        ratio_bad_q <= bcnt_q < 8'(BCLK_PER_LR_MIN);
        bcnt_q      <= 8'h00;
      end else if (bclk_rise && bcnt_q != 8'hFF) begin
        bcnt_q <= bcnt_q + 8'h01;
      end
    end
  end
  wire lr_fault = ratio_bad_q | lr_idle_q >= 32'(LRMISS_CYC);

  // Mute source combination, all registered onto the outputs
  wire areset_d = dig_rst | clk_lost | lr_fault;
  wire gate_d   = areset_d | fzero | automute_q | (mute_req & gain_zero);
  always_ff @(posedge sys_clk_i) begin
    analog_filter_reset_o <= areset_d;
    analog_output_gate_o  <= gate_d;
    filter_init_o         <= areset_d;
    gain_left_o           <= gain_l;
    gain_right_o          <= gain_r;
    deemph_rate_o <= ctrl2_q[DEM_BIT] ? dmc_deemph_t'(ctrl3_q[SF_LSB+1:SF_LSB])
                                       : DEEMPH_NONE;
  end

  // Output routing, refreshed once per sample
  wire [SMP_W-1:0] l = smp_left_i;
  wire [SMP_W-1:0] r = smp_right_i;
  dmc_quad_t route_d;
  always_comb begin
    case (mode)
      ROUTE_MONO_L: route_d = '{lp: l, ln: neg_sat(l), rp: neg_sat(l), rn: l};
      ROUTE_MONO_R: route_d = '{lp: neg_sat(r), ln: r, rp: r, rn: neg_sat(r)};
      ROUTE_SWAP:   route_d = '{lp: r, ln: neg_sat(r), rp: l, rn: neg_sat(l)};
      default:      route_d = '{lp: l, ln: neg_sat(l), rp: r, rn: neg_sat(r)};
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (dig_rst || (smp_valid_i && fzero)) begin
      dac_out_o <= '0;
    end else if (smp_valid_i) begin
      dac_out_o <= route_d;
    end
  end

  // Checks
  property p_locked;
    @(posedge sys_clk_i) disable iff (rst_i) !unlock_q |-> route_q == ROUTE_STEREO;
  endproperty
  a_locked: assert property (p_locked) else $error("route changed while locked");
  property p_key;
    @(posedge sys_clk_i) disable iff (dig_rst) key_hit |=> unlock_q;
  endproperty
  a_key: assert property (p_key) else $error("key write did not unlock");
  property p_mono_l;
    @(posedge sys_clk_i) disable iff (dig_rst)
      $past(smp_valid_i) && $past(mode) == ROUTE_MONO_L && !$past(fzero)
      |-> dac_out_o.rn == dac_out_o.lp && dac_out_o.rp == dac_out_o.ln
          && dac_out_o.lp == $past(smp_left_i);
  endproperty
  a_mono_l: assert property (p_mono_l) else $error("mono left routing wrong");
  property p_mono_r;
    @(posedge sys_clk_i) disable iff (dig_rst)
      $past(smp_valid_i) && $past(mode) == ROUTE_MONO_R && !$past(fzero)
      |-> dac_out_o.ln == $past(smp_right_i) && dac_out_o.rp == dac_out_o.ln
          && dac_out_o.rn == dac_out_o.lp;
  endproperty
  a_mono_r: assert property (p_mono_r) else $error("mono right routing wrong");
  property p_auto_en;
    @(posedge sys_clk_i) disable iff (dig_rst)
      automute_q |-> $past(zde) && zcnt_q == 11'(ZERO_SAMPLES);
  endproperty
  a_auto_en: assert property (p_auto_en) else $error("automute without cause");
  property p_auto_clr;
    @(posedge sys_clk_i) disable iff (dig_rst) smp_valid_i && !smp_zero |=> !automute_q;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("non-zero kept automute");
  property p_loss;
    @(posedge sys_clk_i) disable iff (dig_rst)
      grd_q == GRD_LOST |=> analog_output_gate_o && analog_filter_reset_o && filter_init_o;
  endproperty
  a_loss: assert property (p_loss) else $error("clock loss not muting");
  property p_cdd;
    @(posedge sys_clk_i) disable iff (dig_rst) cdd_q && $past(cdd_q) |-> grd_q != GRD_LOST;
  endproperty
  a_cdd: assert property (p_cdd) else $error("clock guard active while disabled");
  property p_mute_zero;
    @(posedge sys_clk_i) disable iff (dig_rst) mute_req && gain_zero |=> analog_output_gate_o;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("no gate at zero gain");
  property p_reset;
    @(posedge sys_clk_i) pin_rst |=> analog_output_gate_o && analog_filter_reset_o ##1
      gain_left_o == GAIN_0DB && gain_right_o == GAIN_0DB;
  endproperty
  a_reset: assert property (p_reset) else $error("reset pin effect missing");
  property p_fzero;
    @(posedge sys_clk_i) disable iff (dig_rst)
      $past(smp_valid_i) && $past(fzero) |-> dac_out_o == '0;
  endproperty
  a_fzero: assert property (p_fzero) else $error("force zero not applied");
  property p_or;
    @(posedge sys_clk_i) disable iff (rst_i)
      $past(automute_q) || $past(lr_fault) |-> analog_output_gate_o;
  endproperty
  a_or: assert property (p_or) else $error("gate missing a source");
  c_auto:   cover property (@(posedge sys_clk_i) $rose(automute_q));
  c_loss:   cover property (@(posedge sys_clk_i) grd_q == GRD_RESTART);
  c_monor:  cover property (@(posedge sys_clk_i) unlock_q && mode == ROUTE_MONO_R);
  c_rampdn: cover property (@(posedge sys_clk_i) mute_req && $rose(gain_zero));
endmodule : dmc_mute_ctrl

// ==== sim/dmc_host_model.sv ====
// Host model that writes control words over the three-pin serial port
`timescale 1ns/10ps
module dmc_host_model (
  input  wire logic sys_clk_i,
  output logic      ctl_clk_o,
  output logic      ctl_data_o,
  output logic      ctl_latch_o
);
  import dmc_pkg::*;

  // Idle levels: clock low, latch high
  initial begin
    ctl_clk_o   = 1'b0;
    ctl_data_o  = 1'b0;
    ctl_latch_o = 1'b1;
  end

  // Every level is held three clocks so the pin synchroniser sees it
  task automatic hold3();
    repeat (3) @(posedge sys_clk_i);
  endtask : hold3

  // One 16-bit word, MSB first; address and data sit in the low 12 bits
  task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    logic [CW_BITS-1:0] word;
    word = {4'h0, addr, data};
    @(posedge sys_clk_i);
    ctl_latch_o <= 1'b0;
    for (int i = CW_BITS - 1; i >= 0; i--) begin
      ctl_data_o <= word[i];
      hold3();
      ctl_clk_o <= 1'b1;
      hold3();
      ctl_clk_o <= 1'b0;
    end
    hold3();
    ctl_latch_o <= 1'b1;
    // Released data line shows the inverse, so a stale bit cannot pass
    ctl_data_o  <= ~word[0];
    repeat (8) @(posedge sys_clk_i);
  endtask : write_reg
endmodule : dmc_host_model

// ==== sim/tb.sv ====
// Self-checking bench for the DAC mute and output-mode control block
`timescale 1ns/10ps
module tb;
  import dmc_pkg::*;
  localparam int LOSS = 20;
  localparam int LRMISS = 200;
  localparam logic [SMP_W-1:0] SL = 24'h123456;
  localparam logic [SMP_W-1:0] SR = 24'h0ABCDE;
  logic             sys_clk_i   = 1'b0;
  logic             rst_i       = 1'b1;
  logic             reset_pin_n = 1'b1;
  logic             mute_pin_n  = 1'b1;
  logic             mclk        = 1'b0;
  logic             lrclk       = 1'b0;
  logic             bclk        = 1'b0;
  logic             mclk_run    = 1'b1;
  logic             lr_run      = 1'b1;
  logic             bclk_run    = 1'b1;
  logic             smp_valid   = 1'b0;
  logic [SMP_W-1:0] smp_l       = '0;
  logic [SMP_W-1:0] smp_r       = '0;
  logic             ctl_clk;
  logic             ctl_data;
  logic             ctl_latch;
  dmc_quad_t        dac_out;
  logic [7:0]       gain_l;
  logic [7:0]       gain_r;
  dmc_deemph_t      deemph;
  logic             finit;
  logic             areset;
  logic             gate;
  int               errors      = 0;
  int               compares    = 0;
  int               cnt         = 0;

  dmc_host_model dmc_host_model_i (.sys_clk_i(sys_clk_i), .ctl_clk_o(ctl_clk),
    .ctl_data_o(ctl_data), .ctl_latch_o(ctl_latch));

  dmc_mute_ctrl #(.LOSS_CYC(LOSS), .LRMISS_CYC(LRMISS)) dmc_mute_ctrl_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n),
    .mute_pin_n_i(mute_pin_n), .ctl_clk_i(ctl_clk), .ctl_data_i(ctl_data),
    .ctl_latch_i(ctl_latch), .mclk_i(mclk), .lrclk_i(lrclk), .bclk_i(bclk),
    .smp_valid_i(smp_valid), .smp_left_i(smp_l), .smp_right_i(smp_r),
    .dac_out_o(dac_out), .gain_left_o(gain_l), .gain_right_o(gain_r),
    .deemph_rate_o(deemph), .filter_init_o(finit),
    .analog_filter_reset_o(areset), .analog_output_gate_o(gate));

  // System clock, 8 ns period
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Audio clocks; 40 bit-clock rises per frame half, flags stop them
  always @(posedge sys_clk_i) begin
    cnt <= cnt + 1;
    if (mclk_run && cnt % 4 == 0) mclk <= ~mclk;
    if (bclk_run && cnt % 2 == 0) bclk <= ~bclk;
    if (lr_run && cnt % 160 == 0) lrclk <= ~lrclk;
  end

  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %b", $time, msg, got);
    end
  endtask : chk_bit

  task automatic chk_vec(input logic [95:0] got, input logic [95:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_vec

  task automatic wr(input logic [2:0] a, input logic [8:0] d);
    dmc_host_model_i.write_reg(a, d);
    // Step off the edge so later checks see settled outputs
    #1;
  endtask : wr

  task automatic wait_chk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_chk

  // n back-to-back sample pairs, then settle
  task automatic feed(input int n, input logic [SMP_W-1:0] l, input logic [SMP_W-1:0] r);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      smp_valid <= 1'b1;
      smp_l     <= l;
      smp_r     <= r;
    end
    @(posedge sys_clk_i);
    smp_valid <= 1'b0;
    wait_chk(4);
  endtask : feed

  // Streams samples until both gains reach g; bounded by a full ramp
  task automatic ramp_to(input logic [7:0] g, output int n);
    n = 0;
    while (!(gain_l === g && gain_r === g)) begin
      if (n > 34000) begin
        errors++;
        $display("ERROR %0t: gain ramp timeout", $time);
        break;
      end
      @(posedge sys_clk_i);
      smp_valid <= 1'b1;
      smp_l     <= SL;
      smp_r     <= SR;
      n++;
      #1;
    end
    @(posedge sys_clk_i);
    smp_valid <= 1'b0;
  endtask : ramp_to

  // Negation is the inverted channel
  function automatic dmc_quad_t route_exp(input dmc_route_t m);
    case (m)
      ROUTE_STEREO: return {SL, -SL, SR, -SR};
      ROUTE_SWAP:   return {SR, -SR, SL, -SL};
      ROUTE_MONO_L: return {SL, -SL, -SL, SL};
      default:      return {-SR, SR, SR, -SR};
    endcase
  endfunction : route_exp

  task automatic sc_reset_state();
    chk_bit(areset, 1'b1, "reset areset");
    chk_bit(gate, 1'b1, "reset gate");
    chk_bit(finit, 1'b1, "reset finit");
    chk_vec(96'({gain_l, gain_r}), 96'(16'hFFFF), "reset gain");
  endtask : sc_reset_state

  task automatic sc_route();
    wr(ADDR_ROUTE, 9'h010);
    feed(1, SL, SR);
    chk_vec(dac_out, route_exp(ROUTE_STEREO), "locked route");
    wr(ADDR_CTRL2, 9'h1E0);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_ROUTE, 9'(m << ROUTE_LSB));
      feed(2, SL, SR);
      chk_vec(dac_out, route_exp(dmc_route_t'(m)), "route mode");
    end
  endtask : sc_route

  task automatic sc_deemph();
    wr(ADDR_CTRL3, 9'h0C0);
    wait_chk(2);
    chk_vec(96'(deemph), 96'(DEEMPH_NONE), "deemph off");
    wr(ADDR_CTRL2, 9'h002);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL3, 9'(s << SF_LSB));
      chk_vec(96'(deemph), 96'(s), "deemph rate");
    end
  endtask : sc_deemph

  task automatic sc_force_zero();
    wr(ADDR_CTRL2, 9'h006);
    feed(2, SL, SR);
    chk_vec(dac_out, '0, "force zero");
    chk_bit(finit, 1'b0, "force zero finit");
    chk_bit(gate, 1'b1, "force zero gate");
    wr(ADDR_CTRL2, 9'h000);
  endtask : sc_force_zero

  task automatic sc_automute();
    feed(1100, '0, '0);
    chk_bit(gate, 1'b0, "zero detect off");
    wr(ADDR_CTRL3, 9'h100);
    feed(1, SL, SR);
    feed(1023, '0, '0);
    chk_bit(gate, 1'b0, "1023 zeros");
    feed(1, '0, '0);
    chk_bit(gate, 1'b1, "1024 zeros");
    chk_bit(areset, 1'b0, "automute areset");
    chk_bit(finit, 1'b0, "automute finit");
    chk_vec(96'(gain_l), 96'(GAIN_0DB), "automute gain");
    feed(1, SL, SR);
    chk_bit(gate, 1'b0, "non-zero clears");
    wr(ADDR_CTRL3, 9'h000);
  endtask : sc_automute

  task automatic sc_soft_mute();
    int n;
    // Stored attenuation below 0dB, so release must return to it
    wr(ADDR_ATTEN_L, 9'h0F0);
    wr(ADDR_ATTEN_R, 9'h1F0);
    ramp_to(8'hF0, n);
    wr(ADDR_CTRL2, 9'h001);
    chk_bit(gate, 1'b0, "gate before zero gain");
    ramp_to(GAIN_ZERO, n);
    chk_bit(n >= 239 * 128 && n <= 240 * 128 + 10, 1'b1, "ramp down rate");
    wait_chk(2);
    chk_bit(gate, 1'b1, "gate at zero gain");
    chk_bit(finit, 1'b0, "soft mute finit");
    wr(ADDR_CTRL2, 9'h000);
    ramp_to(8'hF0, n);
    chk_bit(n >= 239 * 128 && n <= 240 * 128 + 10, 1'b1, "ramp up rate");
    wait_chk(3);
    chk_bit(gate, 1'b0, "gate released");
  endtask : sc_soft_mute

  task automatic sc_pins();
    @(posedge sys_clk_i);
    mute_pin_n <= 1'b0;
    feed(300, SL, SR);
    chk_bit(gain_l inside {8'hED, 8'hEE}, 1'b1, "mute pin ramp");
    wr(ADDR_CTRL3, 9'h0C0);
    wr(ADDR_CTRL2, 9'h002);
    chk_vec(96'(deemph), 96'(DEEMPH_32K), "deemph before reset");
    @(posedge sys_clk_i);
    reset_pin_n <= 1'b0;
    wait_chk(6);
    sc_reset_state();
    @(posedge sys_clk_i);
    reset_pin_n <= 1'b1;
    mute_pin_n  <= 1'b1;
    wait_chk(8);
    chk_vec(96'(deemph), 96'(DEEMPH_NONE), "registers cleared");
    wr(ADDR_ROUTE, 9'h010);
    feed(1, SL, SR);
    chk_vec(dac_out, route_exp(ROUTE_STEREO), "relocked");
  endtask : sc_pins

  task automatic sc_clock_loss();
    wr(ADDR_CTRL2, 9'h1E0);
    wr(ADDR_ROUTE, 9'h020);
    @(posedge sys_clk_i);
    mclk_run <= 1'b0;
    wait_chk(LOSS + 6);
    chk_bit(areset, 1'b1, "loss areset");
    chk_bit(gate, 1'b1, "loss gate");
    chk_bit(finit, 1'b1, "loss finit");
    @(posedge sys_clk_i);
    mclk_run <= 1'b1;
    wait_chk(20);
    chk_bit(areset, 1'b0, "restart areset");
    feed(1, SL, SR);
    chk_vec(dac_out, route_exp(ROUTE_SWAP), "route kept");
    wr(ADDR_ROUTE, 9'h060);
    @(posedge sys_clk_i);
    mclk_run <= 1'b0;
    wait_chk(LOSS + 20);
    chk_bit(areset, 1'b0, "guard off areset");
    chk_bit(gate, 1'b0, "guard off gate");
    @(posedge sys_clk_i);
    mclk_run <= 1'b1;
  endtask : sc_clock_loss

  task automatic sc_frame_loss();
    @(posedge sys_clk_i);
    lr_run <= 1'b0;
    wait_chk(LRMISS + 10);
    chk_bit(areset, 1'b1, "frame areset");
    chk_bit(gate, 1'b1, "frame gate");
    chk_bit(finit, 1'b1, "frame finit");
    @(posedge sys_clk_i);
    lr_run <= 1'b1;
    wait_chk(800);
    chk_bit(areset, 1'b0, "frame restart");
    feed(1, SL, SR);
    chk_vec(dac_out, route_exp(ROUTE_SWAP), "frame route kept");
    // Too few bit clocks per frame counts as a bad ratio
    @(posedge sys_clk_i);
    bclk_run <= 1'b0;
    wait_chk(800);
    chk_bit(areset, 1'b1, "ratio areset");
    chk_bit(gate, 1'b1, "ratio gate");
    @(posedge sys_clk_i);
    bclk_run <= 1'b1;
    wait_chk(800);
    chk_bit(areset, 1'b0, "ratio restart");
  endtask : sc_frame_loss

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    sc_reset_state();
    chk_vec(dac_out, '0, "reset outputs");
    wait_chk(4);
    sc_route();
    sc_deemph();
    sc_force_zero();
    sc_automute();
    sc_soft_mute();
    sc_pins();
    sc_clock_loss();
    sc_frame_loss();
    print_verdict();
  end
endmodule : tb
